// >>> inc/hlc_pkg.sv
`default_nettype none

package hlc_pkg;

    // register byte addresses on the bus
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_RX_DATA = 8'h08;
    localparam logic [7:0] ADDR_TX_DATA = 8'h0C;

    // control register fields
    localparam int CTRL_FILL_SELECT = 4;
    localparam int CTRL_TX_RESET = 5;
    localparam int CTRL_RX_RESET = 6;
    localparam int CTRL_REMOTE_ALARM = 7;
    localparam int CTRL_TX_LOW_LSB = 10;
    localparam int CTRL_RX_HIGH_LSB = 13;
    localparam int LEVEL_SEL_W = 3;
    localparam logic [15:0] CTRL_RESET = 16'h0000;

    // status register fields; bits 5..0 are sticky, write one to clear
    localparam int ST_RX_START = 0;
    localparam int ST_RX_END = 1;
    localparam int ST_RX_OVERRUN = 2;
    localparam int ST_RX_ABORT = 3;
    localparam int ST_TX_END = 4;
    localparam int ST_TX_UNDERRUN = 5;
    localparam int STICKY_W = 6;
    localparam int ST_RX_HIGH = 6;
    localparam int ST_TX_LOW = 7;
    localparam int ST_RX_EMPTY = 8;
    localparam int ST_TX_LEVEL_LSB = 16;

    // receive data word and transmit data word fields
    localparam int RX_WORD_W = 12;
    localparam int RXD_EMPTY = 12;
    localparam int TX_WORD_W = 9;

    // line bytes, sent least significant bit first
    localparam logic [7:0] FLAG_BYTE = 8'h7E;
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    localparam logic [7:0] ABORT_BYTE = 8'hFE;

    // frame check sequence, reflected form
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_GOOD = 16'hF0B8;

    // packet status codes in the closing byte
    localparam logic [1:0] PS_GOOD = 2'h0;
    localparam logic [1:0] PS_CRC_ERR = 2'h1;
    localparam logic [1:0] PS_SHORT = 2'h2;
    localparam logic [1:0] PS_ABORT = 2'h3;

    // watermark threshold = base + step * select code
    localparam int WM_BASE = 16;
    localparam int WM_STEP = 32;

    // bit run lengths and counts
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [2:0] FLAG_RUN = 3'h6;
    localparam logic [2:0] ONES_MAX = 3'h7;
    localparam logic [2:0] DELAY_FULL = 3'h7;
    localparam logic [3:0] BYTE_LAST = 4'h7;
    localparam logic [1:0] HOLD_FULL = 2'h3;
    localparam int TX_START_MIN = 2;

    typedef enum logic [2:0] {
        TX_ABORT, TX_FILL, TX_OPEN, TX_DATA, TX_CRC_LO, TX_CRC_HI, TX_CLOSE
    } hlc_tx_state_type;

endpackage

`default_nettype wire

// >>> logic/hlc_link_controller.sv
// Operation
// [RULE1] separate 256-byte packet buffers for transmit and receive
// [RULE2] receive reset empties receive buffer and restarts packet search
// [RULE3] receiver destuffs, aligns to bytes, stores each byte as it arrives
// [RULE4] first stored byte of every packet carries the opening marker
// [RULE5] closing flag: check CRC, mark last byte, drop CRC, report status
// [RULE6] packets may be split by one flag or two sharing a zero
// [RULE7] receive buffer overflow drops new data and sets overrun flag
// [RULE8] after overrun, refuse packets until buffer empty or receive reset
// [RULE9] seven ones set abort flag; inside a packet, status shows abort
// [RULE10] flag packet start on new message and packet end on completion
// [RULE11] flag occupancy above high mark; empty flag; host pops one byte
// [RULE12] transmit reset flushes buffer, sends one abort, then fill bytes
// [RULE13] no packet starts until transmit buffer holds two bytes; after a closing flag the code opens the next on one byte
// [RULE14] each packet opens with a flag and its bits are zero-stuffed
// [RULE15] at end-marked byte append 16-bit CRC then a closing flag
// [RULE16] after packet send fill if empty, else open and send next
// [RULE17] at least two flags always stand between consecutive packets
// [RULE18] buffer empty before end byte: send abort, fill, set underrun
// [RULE19] host resets transmit section after an underrun
// [RULE20] flag packet sent; flag occupancy below the low mark
// [RULE21] host never overfills the transmit buffer, watches its level
// [RULE22] remote alarm only while idle; packet pre-empts, alarm resumes
// [RULE23] each section reset fires on a zero-to-one control bit edge
// [RULE24] fill select zero sends flags, one sends all-ones idle bytes
// [RULE25] three-bit level selects give 16 to 240 bytes in steps of 32
// [RULE26] insert a zero after five ones; receiver deletes such a zero
`default_nettype none

module hlc_link_controller #(
    parameter int DEPTH = 256,
    parameter logic ALARM_LEVEL = 1'b1
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // overhead bit slots from the framer, same clock
    input wire logic line_bit_tick,
    input wire logic rx_bit_valid,
    input wire logic rx_m_bit,
    // overhead bit stream to the framer
    output logic tx_m_bit,
    output logic tx_alarm_active
);

    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    typedef struct packed {
        logic [15:0] ctrl;
        logic [hlc_pkg::STICKY_W-1:0] sticky;
        logic [31:0] hrdata;
        logic a_sel;
        logic a_write;
        logic [7:0] a_addr;
        logic [DEPTH-1:0][hlc_pkg::TX_WORD_W-1:0] tx_mem;
        logic [AW-1:0] tx_wp;
        logic [AW-1:0] tx_rp;
        logic [CW-1:0] tx_cnt;
        logic [DEPTH-1:0][hlc_pkg::RX_WORD_W-1:0] rx_mem;
        logic [AW-1:0] rx_wp;
        logic [AW-1:0] rx_rp;
        logic [CW-1:0] rx_cnt;
        hlc_pkg::hlc_tx_state_type tx_state;
        logic [7:0] tx_sh;
        logic [3:0] tx_bits;
        logic [2:0] tx_ones;
        logic tx_stuff_pend;
        logic tx_end_pend;
        logic [15:0] tx_crc;
        logic tx_halt;
        logic tx_bit;
        logic alarm_active;
        logic [2:0] rx_ones;
        logic [6:0] rx_dly;
        logic [2:0] rx_dcnt;
        logic rx_in_frame;
        logic [7:0] rx_bsh;
        logic [3:0] rx_bcnt;
        logic [15:0] rx_crc;
        logic [2:0][7:0] rx_hold;
        logic [1:0] rx_hcnt;
        logic rx_first;
        logic rx_blocked;
    } hlc_state_type;

    hlc_state_type q;
    hlc_state_type n;

    // one bit of the reflected frame check sequence
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic d);
        logic [15:0] s;
        s = {1'b0, c[15:1]};
        if (c[0] ^ d) begin
            s = s ^ hlc_pkg::CRC_POLY;
        end
        return s;
    endfunction

    // whole next-state function
    always_comb begin
        logic tx_push;
        logic tx_pop;
        logic rx_push;
        logic rx_pop;
        logic tx_rst;
        logic rx_rst;
        logic b;
        logic d;
        logic d_valid;
        logic e;
        logic byte_done;
        logic is_flag;
        logic is_abort;
        logic stuffing;
        logic [8:0] tx_word;
        logic [8:0] tx_head;
        logic [11:0] rx_word;
        logic [7:0] rx_byte;
        logic [7:0] fill_byte;
        logic [15:0] crc_now;
        logic [1:0] ps;
        logic [CW-1:0] tx_thr;
        logic [CW-1:0] rx_thr;
        logic [31:0] status_w;
        n = q;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        tx_rst = 1'b0;
        rx_rst = 1'b0;
        b = 1'b0;
        d = 1'b0;
        d_valid = 1'b0;
        e = q.rx_dly[0];
        byte_done = 1'b0;
        is_flag = 1'b0;
        is_abort = 1'b0;
        stuffing = 1'b0;
        tx_word = '0;
        tx_head = q.tx_mem[q.tx_rp];
        rx_word = '0;
        rx_byte = {e, q.rx_bsh[7:1]};
        crc_now = q.tx_crc;
        ps = hlc_pkg::PS_GOOD;
        fill_byte = q.ctrl[hlc_pkg::CTRL_FILL_SELECT] ?
            hlc_pkg::IDLE_BYTE : hlc_pkg::FLAG_BYTE; // [RULE24]

        // watermark thresholds from the three-bit selects [RULE25]
        tx_thr = CW'(hlc_pkg::WM_BASE + hlc_pkg::WM_STEP *
            int'(q.ctrl[hlc_pkg::CTRL_TX_LOW_LSB +: hlc_pkg::LEVEL_SEL_W]));
        rx_thr = CW'(hlc_pkg::WM_BASE + hlc_pkg::WM_STEP *
            int'(q.ctrl[hlc_pkg::CTRL_RX_HIGH_LSB +: hlc_pkg::LEVEL_SEL_W]));

        // status word: sticky events, live levels and the transmit depth
        status_w = '0;
        status_w[hlc_pkg::STICKY_W-1:0] = q.sticky;
        status_w[hlc_pkg::ST_RX_HIGH] = q.rx_cnt > rx_thr; // [RULE11]
        status_w[hlc_pkg::ST_TX_LOW] = q.tx_cnt < tx_thr; // [RULE20]
        status_w[hlc_pkg::ST_RX_EMPTY] = q.rx_cnt == '0; // [RULE11]
        status_w[hlc_pkg::ST_TX_LEVEL_LSB +: CW] = q.tx_cnt;

        // address phase: reads answer from here so hrdata is a flop
        n.a_sel = hsel && htrans[1] && hready;
        n.a_write = hwrite;
        n.a_addr = haddr[7:0];
        if (hsel && htrans[1] && hready && !hwrite) begin
            n.hrdata = '0;
            case (haddr[7:0])
                hlc_pkg::ADDR_CTRL: n.hrdata[15:0] = q.ctrl;
                hlc_pkg::ADDR_STATUS: n.hrdata = status_w;
                hlc_pkg::ADDR_RX_DATA: begin
                    // one byte per read; empty reads return only the flag
                    rx_pop = q.rx_cnt != '0; // [RULE11]
                    if (rx_pop) begin
                        n.hrdata[hlc_pkg::RX_WORD_W-1:0] = q.rx_mem[q.rx_rp];
                    end
                    n.hrdata[hlc_pkg::RXD_EMPTY] = !rx_pop;
                end
                default: n.hrdata = '0;
            endcase
        end

        // data phase of writes
        if (q.a_sel && q.a_write) begin
            case (q.a_addr)
                hlc_pkg::ADDR_CTRL: begin
                    n.ctrl = hwdata[15:0];
                    tx_rst = hwdata[hlc_pkg::CTRL_TX_RESET] &&
                        !q.ctrl[hlc_pkg::CTRL_TX_RESET]; // [RULE23]
                    rx_rst = hwdata[hlc_pkg::CTRL_RX_RESET] &&
                        !q.ctrl[hlc_pkg::CTRL_RX_RESET]; // [RULE23]
                end
                hlc_pkg::ADDR_STATUS: begin
                    n.sticky = q.sticky & ~hwdata[hlc_pkg::STICKY_W-1:0];
                end
                hlc_pkg::ADDR_TX_DATA: begin
                    // a write to a full buffer is dropped
                    tx_push = q.tx_cnt != FULL;
                    tx_word = hwdata[hlc_pkg::TX_WORD_W-1:0];
                end
                default: ;
            endcase
        end

        // transmit bit engine, one bit per overhead slot
        if (line_bit_tick) begin
            if (q.tx_stuff_pend) begin
                n.tx_bit = q.alarm_active ? ALARM_LEVEL : 1'b0; // [RULE26]
                n.tx_ones = '0;
                n.tx_stuff_pend = 1'b0;
            end else begin
                b = q.tx_sh[0];
                stuffing = q.tx_state == hlc_pkg::TX_DATA ||
                    q.tx_state == hlc_pkg::TX_CRC_LO ||
                    q.tx_state == hlc_pkg::TX_CRC_HI;
                n.tx_bit = q.alarm_active ? ALARM_LEVEL : b;
                n.tx_sh = {1'b0, q.tx_sh[7:1]};
                n.tx_ones = !b ? 3'h0 :
                    (q.tx_ones == hlc_pkg::ONES_MAX) ? q.tx_ones :
                    q.tx_ones + 3'h1;
                n.tx_stuff_pend = stuffing && b && // [RULE14]
                    q.tx_ones == hlc_pkg::STUFF_RUN - 3'h1; // [RULE26]
                if (q.tx_state == hlc_pkg::TX_DATA) begin
                    crc_now = crc_step(q.tx_crc, b);
                    n.tx_crc = crc_now;
                end
                n.tx_bits = q.tx_bits + 4'h1;
                if (q.tx_bits == hlc_pkg::BYTE_LAST) begin
                    n.tx_bits = '0;
                    unique case (q.tx_state)
                        hlc_pkg::TX_ABORT, hlc_pkg::TX_FILL: begin
                            if (!q.tx_halt &&
                                q.tx_cnt >= CW'(hlc_pkg::TX_START_MIN)) begin
                                // a ready packet pre-empts the alarm
                                n.tx_state = hlc_pkg::TX_OPEN; // [RULE13]
                                n.tx_sh = hlc_pkg::FLAG_BYTE;
                                n.alarm_active = 1'b0; // [RULE22]
                            end else begin
                                n.tx_state = hlc_pkg::TX_FILL;
                                n.tx_sh = fill_byte;
                                n.alarm_active = // [RULE22]
                                    q.ctrl[hlc_pkg::CTRL_REMOTE_ALARM];
                            end
                        end
                        hlc_pkg::TX_OPEN: begin
                            tx_pop = 1'b1;
                            n.tx_sh = tx_head[7:0];
                            n.tx_end_pend = tx_head[8];
                            n.tx_crc = hlc_pkg::CRC_INIT;
                            n.tx_state = hlc_pkg::TX_DATA; // [RULE14]
                        end
                        hlc_pkg::TX_DATA: begin
                            if (q.tx_end_pend) begin
                                n.tx_state = hlc_pkg::TX_CRC_LO; // [RULE15]
                                n.tx_sh = ~crc_now[7:0];
                            end else if (q.tx_cnt == '0) begin
                                // buffer ran dry inside the packet
                                n.tx_state = hlc_pkg::TX_ABORT; // [RULE18]
                                n.tx_sh = hlc_pkg::ABORT_BYTE;
                                n.tx_halt = 1'b1;
                                n.sticky[hlc_pkg::ST_TX_UNDERRUN] = 1'b1;
                            end else begin
                                tx_pop = 1'b1;
                                n.tx_sh = tx_head[7:0];
                                n.tx_end_pend = tx_head[8];
                            end
                        end
                        hlc_pkg::TX_CRC_LO: begin
                            n.tx_state = hlc_pkg::TX_CRC_HI; // [RULE15]
                            n.tx_sh = ~q.tx_crc[15:8];
                        end
                        hlc_pkg::TX_CRC_HI: begin
                            n.tx_state = hlc_pkg::TX_CLOSE; // [RULE15]
                            n.tx_sh = hlc_pkg::FLAG_BYTE;
                            n.sticky[hlc_pkg::ST_TX_END] = 1'b1; // [RULE20]
                        end
                        hlc_pkg::TX_CLOSE: begin
                            // two flags between packets [RULE17]
                            if (!q.tx_halt && q.tx_cnt != '0) begin
                                n.tx_state = hlc_pkg::TX_OPEN; // [RULE16]
                                n.tx_sh = hlc_pkg::FLAG_BYTE;
                            end else begin
                                n.tx_state = hlc_pkg::TX_FILL; // [RULE16]
                                n.tx_sh = fill_byte;
                                n.alarm_active = // [RULE22]
                                    q.ctrl[hlc_pkg::CTRL_REMOTE_ALARM];
                            end
                        end
                    endcase
                end
            end
        end

        // receive bit engine: raw ones run, destuffing, flag and abort
        if (rx_bit_valid) begin
            if (rx_m_bit) begin
                n.rx_ones = (q.rx_ones == hlc_pkg::ONES_MAX) ?
                    q.rx_ones : q.rx_ones + 3'h1;
                is_abort = q.rx_ones == hlc_pkg::FLAG_RUN; // [RULE9]
                d_valid = !is_abort;
                d = 1'b1;
            end else begin
                n.rx_ones = '0;
                is_flag = q.rx_ones == hlc_pkg::FLAG_RUN;
                // a zero after five ones is stuffing and is deleted
                d_valid = q.rx_ones < hlc_pkg::STUFF_RUN; // [RULE26]
            end
        end

        // seven-bit delay keeps the flag's own bits out of the data
        if (d_valid) begin
            n.rx_dly = {d, q.rx_dly[6:1]};
            if (q.rx_dcnt != hlc_pkg::DELAY_FULL) begin
                n.rx_dcnt = q.rx_dcnt + 3'h1;
            end else if (q.rx_in_frame) begin
                n.rx_bsh = rx_byte; // [RULE3]
                n.rx_crc = crc_step(q.rx_crc, e);
                n.rx_bcnt = q.rx_bcnt + 4'h1;
                if (q.rx_bcnt == hlc_pkg::BYTE_LAST) begin
                    n.rx_bcnt = '0;
                    byte_done = 1'b1;
                end
            end
        end

        // the last three bytes are held back so the CRC never gets stored
        if (byte_done) begin
            if (q.rx_hcnt == hlc_pkg::HOLD_FULL) begin
                rx_push = 1'b1; // [RULE3]
                rx_word = {hlc_pkg::PS_GOOD, 1'b0, q.rx_first, q.rx_hold[0]};
                n.rx_first = 1'b0; // [RULE4]
                n.rx_hold = {rx_byte, q.rx_hold[2], q.rx_hold[1]};
            end else begin
                n.rx_hold[q.rx_hcnt] = rx_byte;
                n.rx_hcnt = q.rx_hcnt + 2'h1;
                if (q.rx_hcnt == 2'h0 && q.rx_first) begin
                    n.sticky[hlc_pkg::ST_RX_START] = 1'b1; // [RULE10]
                end
            end
        end

        // closing flag ends a packet; every flag may open the next one
        if (is_flag) begin
            if (q.rx_in_frame && q.rx_hcnt != '0) begin
                if (q.rx_hcnt != hlc_pkg::HOLD_FULL || q.rx_bcnt != '0) begin
                    ps = hlc_pkg::PS_SHORT;
                end else if (q.rx_crc != hlc_pkg::CRC_GOOD) begin
                    ps = hlc_pkg::PS_CRC_ERR; // [RULE5]
                end
                rx_push = 1'b1;
                rx_word = {ps, 1'b1, q.rx_first, q.rx_hold[0]}; // [RULE5]
                n.sticky[hlc_pkg::ST_RX_END] = 1'b1; // [RULE10]
            end
            n.rx_in_frame = !q.rx_blocked; // [RULE6] [RULE8]
            n.rx_dcnt = '0;
            n.rx_bcnt = '0;
            n.rx_hcnt = '0;
            n.rx_crc = hlc_pkg::CRC_INIT;
            n.rx_first = 1'b1;
        end

        // abort: always flagged, and closes a packet in progress
        if (is_abort) begin
            n.sticky[hlc_pkg::ST_RX_ABORT] = 1'b1; // [RULE9]
            if (q.rx_in_frame && q.rx_hcnt != '0) begin
                rx_push = 1'b1;
                rx_word = {hlc_pkg::PS_ABORT, 1'b1, q.rx_first,
                    q.rx_hold[0]}; // [RULE9]
                n.sticky[hlc_pkg::ST_RX_END] = 1'b1;
            end
            n.rx_in_frame = 1'b0;
            n.rx_dcnt = '0;
        end

        // overflow drops the byte and locks out packets until drained
        if (rx_push && q.rx_cnt == FULL) begin
            rx_push = 1'b0;
            n.sticky[hlc_pkg::ST_RX_OVERRUN] = 1'b1; // [RULE7]
            n.rx_blocked = 1'b1; // [RULE8]
            n.rx_in_frame = 1'b0;
        end
        if (q.rx_blocked && q.rx_cnt == '0) begin
            n.rx_blocked = 1'b0; // [RULE8]
        end

        // buffer pointers and occupancy of both directions [RULE1]
        if (tx_push) begin
            n.tx_mem[q.tx_wp] = tx_word;
            n.tx_wp = q.tx_wp + 1'b1;
        end
        if (tx_pop) begin
            n.tx_rp = q.tx_rp + 1'b1;
        end
        n.tx_cnt = q.tx_cnt + CW'(tx_push) - CW'(tx_pop);
        if (rx_push) begin
            n.rx_mem[q.rx_wp] = rx_word;
            n.rx_wp = q.rx_wp + 1'b1;
        end
        if (rx_pop) begin
            n.rx_rp = q.rx_rp + 1'b1;
        end
        n.rx_cnt = q.rx_cnt + CW'(rx_push) - CW'(rx_pop);

        // section resets win over everything else in their direction
        if (tx_rst) begin
            n.tx_wp = '0; // [RULE12]
            n.tx_rp = '0;
            n.tx_cnt = '0;
            n.tx_state = hlc_pkg::TX_ABORT;
            n.tx_sh = hlc_pkg::ABORT_BYTE;
            n.tx_bits = '0;
            n.tx_stuff_pend = 1'b0;
            n.tx_halt = 1'b0;
            n.alarm_active = 1'b0;
        end
        if (rx_rst) begin
            n.rx_wp = '0; // [RULE2]
            n.rx_rp = '0;
            n.rx_cnt = '0;
            n.rx_in_frame = 1'b0;
            n.rx_ones = '0;
            n.rx_dcnt = '0;
            n.rx_hcnt = '0;
            n.rx_blocked = 1'b0;
        end
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
            q.ctrl <= hlc_pkg::CTRL_RESET;
            q.tx_state <= hlc_pkg::TX_FILL;
            q.tx_sh <= hlc_pkg::FLAG_BYTE;
            q.tx_crc <= hlc_pkg::CRC_INIT;
            q.rx_crc <= hlc_pkg::CRC_INIT;
        end else begin
            q <= n;
        end
    end

    // outputs; zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = q.hrdata;
    assign tx_m_bit = q.tx_bit;
    assign tx_alarm_active = q.alarm_active;

endmodule

`default_nettype wire

// >>> dv/hlc_chk.sv
`default_nettype none

module hlc_chk #(
    parameter logic ALARM_LEVEL = 1'b1
) (
    // bus
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    // line
    input wire logic line_bit_tick,
    input wire logic tx_m_bit,
    input wire logic tx_alarm_active
);
    logic rd;
    // read address phase taken
    assign rd = hsel && htrans[1] && hready && !hwrite;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not okay");
    AST_RD_HOLD: assert property (!$past(rd) |-> $stable(hrdata))
        else $error("read data moved");
    AST_RX_WORD: assert property ($past(rd && haddr[7:0] == 8'h08)
        |-> hrdata[31:13] == 19'h0 && (!hrdata[12] || hrdata[11:0] == 12'h0))
        else $error("bad receive word");
    AST_CTRL_W: assert property ($past(rd && haddr[7:0] == 8'h00)
        |-> hrdata[31:16] == 16'h0) else $error("control too wide");
    AST_UNMAPPED: assert property ($past(rd && haddr[7:0] == 8'h10)
        |-> hrdata == 32'h0) else $error("unmapped not zero");
    AST_BIT_SLOT: assert property (!$past(line_bit_tick)
        |-> $stable(tx_m_bit)) else $error("bit off slot");
    AST_ALARM_SLOT: assert property ($changed(tx_alarm_active)
        |-> $past(line_bit_tick)) else $error("alarm off slot");
    AST_ALARM_BIT: assert property (tx_alarm_active
        && $past(tx_alarm_active && line_bit_tick)
        |-> tx_m_bit == ALARM_LEVEL) else $error("alarm level wrong");
endmodule

bind hlc_link_controller hlc_chk #(.ALARM_LEVEL(ALARM_LEVEL)) hlc_chk_inst (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
    .hresp, .hrdata, .line_bit_tick, .tx_m_bit, .tx_alarm_active
);

`default_nettype wire

// >>> dv/hlc_line_model.sv
`default_nettype none

module hlc_line_model (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bench stall
    input wire logic run,
    // line side
    input wire logic tx_m_bit,
    output logic line_bit_tick,
    output logic rx_bit_valid,
    output logic rx_m_bit
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_reg;
    logic tick_d_reg;
    // loopback, bit returns two edges after its slot
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= 3'h0;
            line_bit_tick <= 1'b0;
            tick_d_reg <= 1'b0;
            rx_bit_valid <= 1'b0;
            rx_m_bit <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
            line_bit_tick <= run && cnt_reg == 3'h0;
            tick_d_reg <= line_bit_tick;
            rx_bit_valid <= tick_d_reg;
            // toggle off slot so stale bits never look valid
            rx_m_bit <= tick_d_reg ? tx_m_bit : !rx_m_bit;
        end
    end
endmodule

`default_nettype wire

// >>> dv/tb_hdlc_link_controller.sv
`default_nettype none

module tb_hdlc_link_controller;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b1;
    logic hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, q;
    logic hready, tick, rxv, rxb, txb, alarm;
    logic [7:0] seed = 8'h16;
    logic [11:0] exp_q[$];
    int miscompares = 0, check_count = 0, z;

    hlc_link_controller hlc_link_controller_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(), .hrdata(hrdata),
        .line_bit_tick(tick), .rx_bit_valid(rxv), .rx_m_bit(rxb),
        .tx_m_bit(txb), .tx_alarm_active(alarm)
    );
    hlc_line_model hlc_line_model_inst (
        .hclk(hclk), .hresetn(hresetn), .run(run), .tx_m_bit(txb),
        .line_bit_tick(tick), .rx_bit_valid(rxv), .rx_m_bit(rxb)
    );

    initial begin
        forever #5 hclk = !hclk;
    end

    function automatic logic [7:0] nx(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // status with no events, receiver empty
    function automatic logic [31:0] st(input int lvl, input int sel);
        logic low;
        low = lvl < hlc_pkg::WM_BASE + hlc_pkg::WM_STEP * sel;
        return {7'h0, 9'(lvl), 7'h0, 1'b1, low, 7'h0};
    endfunction

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %0t got %h want %h", $time, got, exp);
        end
    endtask

    // single transfer, held until hready
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask

    task automatic wc(input logic [31:0] d);
        bus(1'b1, 8'h00, d, q);
    endtask

    task automatic wait_st(input int b);
        q = 32'h0;
        while (q[b] !== 1'b1) bus(1'b0, 8'h04, 32'h0, q);
    endtask

    // n random bytes, last end-marked if m
    task automatic pkt(input int n, input logic m, input logic keep);
        for (int i = 0; i < n; i++) begin
            seed = nx(seed);
            bus(1'b1, 8'h0C, {23'h0, m && i == n - 1, seed}, q);
            if (keep) exp_q.push_back({2'h0, i == n - 1, i == 0, seed});
        end
    endtask

    // hang guard
    initial begin
        repeat (60000) @(posedge hclk);
        miscompares++;
        close_out();
    end

    initial begin
        hresetn = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rc(8'h00, 32'h0);
        rc(8'h04, st(0, 0));
        rc(8'h10, 32'h0);
        pkt(17, 1'b0, 1'b0);
        rc(8'h04, st(17, 0));
        wc(32'h400);
        rc(8'h04, st(17, 1));
        wc(32'h420);
        rc(8'h04, st(0, 1));
        wc(32'h400);
        run <= 1'b1;
        pkt(3 + seed % 6, 1'b1, 1'b1);
        pkt(3 + seed % 6, 1'b1, 1'b1);
        wait_st(1);
        bus(1'b1, 8'h04, 32'h2, q);
        wait_st(1);
        while (exp_q.size()) rc(8'h08, {20'h0, exp_q.pop_front()});
        rc(8'h08, 32'h1000);
        bus(1'b0, 8'h04, 32'h0, q);
        chk({q[4:3], q[1:0]}, 32'hF);
        pkt(2, 1'b0, 1'b0);
        wait_st(5);
        wc(32'h440);
        wc(32'h400);
        rc(8'h08, 32'h1000);
        wc(32'h420);
        wc(32'h410);
        z = 0;
        repeat (32) @(posedge hclk iff tick);
        repeat (64) begin
            @(posedge hclk iff tick);
            z += !txb;
        end
        chk(z, 0);
        wc(32'h490);
        repeat (32) @(posedge hclk iff tick);
        chk(alarm, 1);
        close_out();
    end
endmodule

`default_nettype wire
